// file: hw/plpm_pkg.sv
package plpm_pkg;

    // Core clock
    localparam int CLK_PERIOD_PS = 5000;

    // Link-loss windows, as times in ns, and their longest cycle counts
    localparam int T1_100_NS  = 1000000;
    localparam int T1_1000_NS = 500000;
    localparam int T1_FAST_NS = 10000;
    localparam int T1_100_CYC  = (T1_100_NS * 1000) / CLK_PERIOD_PS;
    localparam int T1_1000_CYC = (T1_1000_NS * 1000) / CLK_PERIOD_PS;
    localparam int T1_FAST_CYC = (T1_FAST_NS * 1000) / CLK_PERIOD_PS;
    localparam int WIN_W = 18;

    // Link pulse spacing during active sleep
    localparam int NLP_INTERVAL_NS  = 16000000;
    localparam int NLP_INTERVAL_CYC = (NLP_INTERVAL_NS / CLK_PERIOD_PS) * 1000;
    localparam int NLP_W = 22;

    // Register field positions
    localparam int PDOWN_BIT       = 11;
    localparam int SLEEP_FIELD_LSB = 8;
    localparam int TDR_AUTO_BIT    = 7;

    // Sleep field codes
    localparam logic [1:0] SLEEP_ACTIVE_CODE  = 2'h2;
    localparam logic [1:0] SLEEP_PASSIVE_CODE = 2'h3;

    // Downshift
    localparam logic [2:0] DS_LIMIT_RESET = 3'h4;

    // Reflectometry storage
    localparam int          TDR_SLOTS = 5;
    localparam logic [2:0]  TDR_MAX_REFL   = 3'h5;
    localparam logic [2:0]  TDR_MAX_CROSS  = 3'h4;
    localparam int          TDR_TIME_W = 16;

    // Fast link-down criteria
    localparam int CRIT_N = 5;

    typedef enum {
        PWR_ON,
        PWR_DOWN,
        PWR_SLEEP_ACT,
        PWR_SLEEP_PAS
    } plpm_pwr_t;

    typedef enum {
        SPD_1000,
        SPD_100,
        SPD_10
    } plpm_speed_t;

endpackage

// file: hw/plpm_link_loss.sv
`timescale 1ns/1ps
module plpm_link_loss #(
    parameter logic [plpm_pkg::WIN_W-1:0] WIN_100  = 18'h30d40,
    parameter logic [plpm_pkg::WIN_W-1:0] WIN_1000 = 18'h186a0,
    parameter logic [plpm_pkg::WIN_W-1:0] WIN_FAST = 18'h007d0
) (
    // Clock and reset
    input  wire logic                        core_clk,
    input  wire logic                        sys_rst,
    // Link condition
    input  wire logic                        link_up,
    input  wire logic                        speed_gig,
    input  wire logic                        signal_bad,
    // Fast mode configuration and criteria
    input  wire logic                        fast_mode,
    input  wire logic [plpm_pkg::CRIT_N-1:0] crit_en,
    input  wire logic [plpm_pkg::CRIT_N-1:0] crit,
    // Event
    output logic                             link_loss
);

    logic [plpm_pkg::WIN_W-1:0] cnt_reg;
    logic [plpm_pkg::WIN_W-1:0] cnt_next;
    logic [plpm_pkg::WIN_W-1:0] window;
    logic                       bad;
    logic                       hit;

    // Any enabled criterion alone may drop the link in fast mode
    assign bad    = fast_mode ? |(crit & crit_en) : signal_bad;
    assign window = fast_mode ? WIN_FAST : (speed_gig ? WIN_1000 : WIN_100);
    assign hit    = link_up && bad && (cnt_reg == window - 18'h00001);
    assign cnt_next = (!link_up || !bad || hit) ? '0 : cnt_reg + 18'h00001;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign link_loss = hit;

    property p_loss_needs_bad;
        @(posedge core_clk) disable iff (sys_rst)
        link_loss |-> (bad && link_up && $past(bad));
    endproperty
    a_loss_needs_bad: assert property (p_loss_needs_bad)
        else $error("link loss without sustained bad condition");

endmodule

// file: hw/plpm_top.sv
`timescale 1ns/1ps
// Summary of operation
// - Pin or control bit forces power-down
// - Leave power-down by clear or reset
// - Asserted pin holds power-down regardless
// - Sleep code 10b enters active sleep
// - Detected link partner wakes from sleep
// - Active sleep keeps sending link pulses
// - Code 11b gives sleep without pulses
// - Mirror at 10/100 maps A-D, B-C
// - Mirror at gigabit reverses all pairs
// - Mirror enabled by strap or bit
// - Mirror also inverts pair polarity
// - Downshift to 100 after N failures
// - Enhanced: one failure without C/D energy
// - Downshift to 10 after 100 fails
// - Keep first five reflections only
// - Cross fault plus four reflections kept
// - Auto reflectometry on link drop
// - Default window drops link in time
// - Fast mode: any enabled criterion
module plpm_top #(
    parameter logic [plpm_pkg::WIN_W-1:0] WIN_100_CYC  = 18'h30d40,
    parameter logic [plpm_pkg::WIN_W-1:0] WIN_1000_CYC = 18'h186a0,
    parameter logic [plpm_pkg::NLP_W-1:0] NLP_CYC      = 22'h30d400
) (
    // Clock and reset
    input  wire logic                            core_clk,
    input  wire logic                            sys_rst,
    // Power control
    input  wire logic                            power_down_pin,
    input  wire logic                            mode_ctrl_pdown,
    input  wire logic                            soft_reset,
    input  wire logic                            sleep_write,
    input  wire logic [1:0]                      sleep_code,
    input  wire logic                            partner_detect,
    output logic                                 powered_down,
    output logic                                 sleeping,
    output logic                                 mgmt_access_en,
    output logic                                 pdown_bit_clear,
    output logic                                 sleep_field_clear,
    output logic                                 nlp_send,
    // Mirror
    input  wire logic                            mirror_strap,
    input  wire logic                            mirror_cfg_en,
    input  wire logic [3:0]                      pair_in,
    output logic [3:0]                           pair_out,
    output logic                                 mirror_active,
    // Downshift
    input  wire logic                            ds_enable,
    input  wire logic                            ds_enhanced,
    input  wire logic [2:0]                      ds_limit,
    input  wire logic                            ds_restart,
    input  wire logic                            gig_fail,
    input  wire logic                            fast_eth_fail,
    input  wire logic                            energy_cd,
    output logic [1:0]                           speed_sel,
    // Reflectometry
    input  wire logic                            tdr_auto_en,
    input  wire logic                            link_fail,
    input  wire logic                            refl_valid,
    input  wire logic                            refl_cross,
    input  wire logic [plpm_pkg::TDR_TIME_W-1:0] refl_time,
    input  wire logic                            tdr_done,
    output logic                                 tdr_start,
    output logic                                 tdr_busy,
    output logic                                 tdr_results_valid,
    output logic [2:0]                           refl_count,
    output logic [plpm_pkg::TDR_SLOTS*16-1:0]    refl_times,
    output logic                                 cross_found,
    output logic [plpm_pkg::TDR_TIME_W-1:0]      cross_time,
    // Link loss
    input  wire logic                            link_up,
    input  wire logic                            signal_bad,
    input  wire logic                            fast_mode,
    input  wire logic [plpm_pkg::CRIT_N-1:0]     crit_en,
    input  wire logic [plpm_pkg::CRIT_N-1:0]     crit,
    output logic                                 link_loss
);

    // Synchronisers for pins
    logic       pin_m_reg, pin_s_reg;
    logic       lp_m_reg, lp_s_reg;
    logic       st_m_reg, st_s_reg;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pin_m_reg <= 1'b0;
            pin_s_reg <= 1'b0;
            lp_m_reg  <= 1'b0;
            lp_s_reg  <= 1'b0;
        end else begin
            pin_m_reg <= power_down_pin;
            pin_s_reg <= pin_m_reg;
            lp_m_reg  <= partner_detect;
            lp_s_reg  <= lp_m_reg;
        end
    end

    // Strap synchroniser runs through reset, so the strap has settled
    // when the first edge after release samples it
    always_ff @(posedge core_clk) begin
        st_m_reg <= mirror_strap;
        st_s_reg <= st_m_reg;
    end

    // Power state
    plpm_pkg::plpm_pwr_t pwr_reg, pwr_next;
    wire pd_req    = pin_s_reg | mode_ctrl_pdown;
    wire pd_leave  = !pin_s_reg && (!mode_ctrl_pdown || soft_reset);
    wire sleep_act = sleep_write && (sleep_code == plpm_pkg::SLEEP_ACTIVE_CODE);
    wire sleep_pas = sleep_write && (sleep_code == plpm_pkg::SLEEP_PASSIVE_CODE);
    wire in_sleep  = (pwr_reg == plpm_pkg::PWR_SLEEP_ACT) ||
                     (pwr_reg == plpm_pkg::PWR_SLEEP_PAS);
    wire wake      = in_sleep && lp_s_reg;

    always_comb begin
        pwr_next = pwr_reg;
        case (pwr_reg)
            plpm_pkg::PWR_ON: begin
                if (pd_req) begin
                    pwr_next = plpm_pkg::PWR_DOWN;
                end else if (sleep_act) begin
                    pwr_next = plpm_pkg::PWR_SLEEP_ACT;
                end else if (sleep_pas) begin
                    pwr_next = plpm_pkg::PWR_SLEEP_PAS;
                end
            end
            plpm_pkg::PWR_DOWN: begin
                if (pd_leave) begin
                    pwr_next = plpm_pkg::PWR_ON;
                end
            end
            plpm_pkg::PWR_SLEEP_ACT, plpm_pkg::PWR_SLEEP_PAS: begin
                if (pd_req) begin
                    pwr_next = plpm_pkg::PWR_DOWN;
                end else if (wake) begin
                    pwr_next = plpm_pkg::PWR_ON;
                end
            end
            default: pwr_next = plpm_pkg::PWR_ON;
        endcase
    end

    // Link pulse divider, runs only in active sleep
    logic [plpm_pkg::NLP_W-1:0] nlp_cnt_reg;
    wire nlp_hit = (pwr_reg == plpm_pkg::PWR_SLEEP_ACT) &&
                   (nlp_cnt_reg == NLP_CYC - 22'h000001);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pwr_reg     <= plpm_pkg::PWR_ON;
            nlp_cnt_reg <= '0;
        end else begin
            pwr_reg     <= pwr_next;
            nlp_cnt_reg <= (nlp_hit || pwr_reg != plpm_pkg::PWR_SLEEP_ACT) ?
                           '0 : nlp_cnt_reg + 22'h000001;
        end
    end

    assign powered_down      = (pwr_reg == plpm_pkg::PWR_DOWN);
    assign sleeping          = in_sleep;
    assign mgmt_access_en    = 1'b1;
    // Soft reset clears the stored bit so a released pin really wakes
    assign pdown_bit_clear   = powered_down && soft_reset && !pin_s_reg;
    assign sleep_field_clear = wake && !pd_req;
    assign nlp_send          = nlp_hit;

    // Mirror: strap caught once after reset release
    logic strap_taken_reg, strap_val_reg;
    logic [3:0] pair_reg;
    wire  gig_mode = (speed_sel == 2'h0);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            strap_taken_reg <= 1'b0;
            strap_val_reg   <= 1'b0;
        end else if (!strap_taken_reg) begin
            strap_taken_reg <= 1'b1;
            strap_val_reg   <= st_s_reg;
        end
    end

    assign mirror_active = strap_val_reg | mirror_cfg_en;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_pair
            // Gigabit reverses all four; 10/100 uses only C and D outputs
            wire src  = pair_in[3-gi];
            wire used = gig_mode || (gi >= 2);
            wire mapd = used ? ~src : 1'b0;
            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    pair_reg[gi] <= 1'b0;
                end else begin
                    pair_reg[gi] <= mirror_active ? mapd : pair_in[gi];
                end
            end
        end
    endgenerate

    assign pair_out = pair_reg;

    // Downshift
    plpm_pkg::plpm_speed_t spd_reg;
    logic [2:0] fail_cnt_reg;
    wire [2:0] fail_inc = fail_cnt_reg + 3'h1;
    wire to_100 = ds_enable && gig_fail && (spd_reg == plpm_pkg::SPD_1000) &&
                  ((ds_enhanced && !energy_cd) ||
                   (fail_inc >= ds_limit));
    wire to_10  = ds_enable && fast_eth_fail &&
                  (spd_reg == plpm_pkg::SPD_100);

    always_ff @(posedge core_clk) begin
        if (sys_rst || ds_restart || !ds_enable) begin
            spd_reg      <= plpm_pkg::SPD_1000;
            fail_cnt_reg <= '0;
        end else if (to_100) begin
            spd_reg      <= plpm_pkg::SPD_100;
            fail_cnt_reg <= '0;
        end else if (to_10) begin
            spd_reg      <= plpm_pkg::SPD_10;
        end else if (link_up) begin
            fail_cnt_reg <= '0;
        end else if (gig_fail && spd_reg == plpm_pkg::SPD_1000) begin
            fail_cnt_reg <= fail_inc;
        end
    end

    assign speed_sel = (spd_reg == plpm_pkg::SPD_1000) ? 2'h0 :
                       (spd_reg == plpm_pkg::SPD_100)  ? 2'h1 : 2'h2;

    // Link loss detector
    plpm_link_loss #(
        .WIN_100  (WIN_100_CYC),
        .WIN_1000 (WIN_1000_CYC),
        .WIN_FAST (plpm_pkg::WIN_W'(plpm_pkg::T1_FAST_CYC))
    ) u_loss (
        .core_clk   (core_clk),
        .sys_rst    (sys_rst),
        .link_up    (link_up),
        .speed_gig  (gig_mode),
        .signal_bad (signal_bad),
        .fast_mode  (fast_mode),
        .crit_en    (crit_en),
        .crit       (crit),
        .link_loss  (link_loss)
    );

    // Reflectometry capture
    logic [plpm_pkg::TDR_TIME_W-1:0] refl_reg [plpm_pkg::TDR_SLOTS];
    logic [2:0] cnt_reg;
    logic       busy_reg, valid_reg, cross_reg;
    logic [plpm_pkg::TDR_TIME_W-1:0] cross_t_reg;
    wire start   = tdr_auto_en && (link_fail || link_loss) && !busy_reg;
    wire cross_n = refl_valid && refl_cross && !cross_reg;
    wire [2:0] cap = (cross_reg || cross_n) ? plpm_pkg::TDR_MAX_CROSS
                                            : plpm_pkg::TDR_MAX_REFL;
    wire store   = busy_reg && refl_valid && !refl_cross && (cnt_reg < cap);
    wire [2:0] cnt_cl = (cnt_reg > cap) ? cap : cnt_reg;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            busy_reg    <= 1'b0;
            valid_reg   <= 1'b0;
            cross_reg   <= 1'b0;
            cnt_reg     <= '0;
            cross_t_reg <= '0;
        end else if (start) begin
            busy_reg    <= 1'b1;
            valid_reg   <= 1'b0;
            cross_reg   <= 1'b0;
            cnt_reg     <= '0;
        end else if (busy_reg) begin
            if (cross_n) begin
                cross_reg   <= 1'b1;
                cross_t_reg <= refl_time;
                cnt_reg     <= cnt_cl;
            end else if (store) begin
                cnt_reg     <= cnt_reg + 3'h1;
            end
            if (tdr_done) begin
                busy_reg  <= 1'b0;
                valid_reg <= 1'b1;
            end
        end
    end

    generate
        for (gi = 0; gi < plpm_pkg::TDR_SLOTS; gi++) begin : g_slot
            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    refl_reg[gi] <= '0;
                end else if (store && cnt_reg == 3'(gi)) begin
                    refl_reg[gi] <= refl_time;
                end
            end
            assign refl_times[gi*16 +: 16] = refl_reg[gi];
        end
    endgenerate

    assign tdr_start         = start;
    assign tdr_busy          = busy_reg;
    assign tdr_results_valid = valid_reg;
    assign refl_count        = cnt_reg;
    assign cross_found       = cross_reg;
    assign cross_time        = cross_t_reg;

    // Checks
    sequence s_pd_cause;
        pd_req && pwr_reg == plpm_pkg::PWR_ON;
    endsequence

    property p_pd_enter;
        @(posedge core_clk) disable iff (sys_rst)
        s_pd_cause |=> powered_down;
    endproperty
    a_pd_enter: assert property (p_pd_enter)
        else $error("power-down request not honoured");

    property p_pin_holds;
        @(posedge core_clk) disable iff (sys_rst)
        (powered_down && pin_s_reg) |=> powered_down;
    endproperty
    a_pin_holds: assert property (p_pin_holds)
        else $error("left power-down with pin asserted");

    property p_pd_leave;
        @(posedge core_clk) disable iff (sys_rst)
        (powered_down && !pin_s_reg && !mode_ctrl_pdown) |=> !powered_down;
    endproperty
    a_pd_leave: assert property (p_pd_leave)
        else $error("power-down not released");

    property p_sleep_act;
        @(posedge core_clk) disable iff (sys_rst)
        (pwr_reg == plpm_pkg::PWR_ON && !pd_req && sleep_act)
            |=> pwr_reg == plpm_pkg::PWR_SLEEP_ACT;
    endproperty
    a_sleep_act: assert property (p_sleep_act)
        else $error("active sleep not entered");

    property p_wake;
        @(posedge core_clk) disable iff (sys_rst)
        (in_sleep && lp_s_reg && !pd_req) |=> !sleeping;
    endproperty
    a_wake: assert property (p_wake)
        else $error("no wake on partner detect");

    property p_no_nlp_passive;
        @(posedge core_clk) disable iff (sys_rst)
        nlp_send |-> pwr_reg == plpm_pkg::PWR_SLEEP_ACT;
    endproperty
    a_no_nlp_passive: assert property (p_no_nlp_passive)
        else $error("link pulse outside active sleep");

    property p_mirror_gig;
        @(posedge core_clk) disable iff (sys_rst)
        (mirror_active && gig_mode) |=> pair_out[0] == ~$past(pair_in[3]);
    endproperty
    a_mirror_gig: assert property (p_mirror_gig)
        else $error("gigabit mirror mapping wrong");

    property p_mirror_fe;
        @(posedge core_clk) disable iff (sys_rst)
        (mirror_active && !gig_mode) |=> pair_out[3] == ~$past(pair_in[0]);
    endproperty
    a_mirror_fe: assert property (p_mirror_fe)
        else $error("10/100 mirror mapping wrong");

    property p_refl_cap;
        @(posedge core_clk) disable iff (sys_rst)
        refl_count <= (cross_found ? plpm_pkg::TDR_MAX_CROSS
                                   : plpm_pkg::TDR_MAX_REFL);
    endproperty
    a_refl_cap: assert property (p_refl_cap)
        else $error("too many reflections stored");

    property p_ds_10;
        @(posedge core_clk) disable iff (sys_rst)
        (to_10 && !ds_restart && !to_100) |=> speed_sel == 2'h2;
    endproperty
    a_ds_10: assert property (p_ds_10)
        else $error("no fallback to 10M");

endmodule

// file: bench/plpm_far_model.sv
`timescale 1ns/1ps
module plpm_far_model (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    // Scenario controls
    input  wire logic        plugged,
    input  wire logic [3:0]  n_refl,
    input  wire logic [3:0]  cross_at,
    // Block side
    input  wire logic        tdr_start,
    output logic             partner_detect = 1'b0,
    output logic             refl_valid = 1'b0,
    output logic             refl_cross = 1'b0,
    output logic [15:0]      refl_time = 16'h0000,
    output logic             tdr_done = 1'b0
);
    logic       run = 1'b0;
    logic [3:0] idx = 4'h0;

    always_ff @(posedge core_clk) begin
        refl_valid <= 1'b0;
        tdr_done <= 1'b0;
        // Released lines wander so stale values never look valid
        refl_cross <= ~refl_cross;
        refl_time <= ~refl_time;
        partner_detect <= plugged;
        if (sys_rst) begin
            run <= 1'b0;
        end else if (tdr_start) begin
            run <= 1'b1;
            idx <= 4'h0;
        end else if (run) begin
            idx <= idx + 4'h1;
            if (idx < n_refl) begin
                refl_valid <= 1'b1;
                refl_cross <= (idx == cross_at);
                // Raw arrival time only, distance is the host's job
                refl_time <= 16'h0100 + 16'(idx);
            end else begin
                tdr_done <= 1'b1;
                run <= 1'b0;
            end
        end
    end
endmodule

// file: bench/plpm_top_test.sv
`timescale 1ns/1ps
module plpm_top_test;
    logic core_clk = 0, sys_rst = 1, pin = 0, pdb = 0, srst = 0;
    logic swr = 0, mcfg = 0, dse = 0, dsx = 0, dsr = 0, gf = 0;
    logic ff = 0, ecd = 1, tae = 0, lf = 0, lup = 0, sbad = 0;
    logic fm = 0, plug = 0, strap = 0, pdc, sfc, nlp, mact, macc, tst, busy;
    logic tval, cfound, pd, slp, pdet, rv, rc, td, ll;
    logic [1:0] code = 0, spd;
    logic [3:0] pin4 = 4'h1, pout, nr = 0, ca = 4'hf;
    logic [4:0] cen = 0, crit = 0;
    logic [2:0] ds_lim = 3'h4, rcnt;
    logic [15:0] rt, ctime;
    logic [79:0] rts;
    int failures = 0, tests_run = 0, cycles = 0, nlp_n, ll_n, st_n, sf_n;

    plpm_top #(.WIN_100_CYC(18'h14), .WIN_1000_CYC(18'ha),
        .NLP_CYC(22'h8)) dut_u (
        .core_clk(core_clk), .sys_rst(sys_rst),
        .power_down_pin(pin), .mode_ctrl_pdown(pdb),
        .soft_reset(srst), .sleep_write(swr), .sleep_code(code),
        .partner_detect(pdet), .powered_down(pd), .sleeping(slp),
        .mgmt_access_en(macc), .pdown_bit_clear(pdc),
        .sleep_field_clear(sfc), .nlp_send(nlp),
        .mirror_strap(strap), .mirror_cfg_en(mcfg), .pair_in(pin4),
        .pair_out(pout), .mirror_active(mact), .ds_enable(dse),
        .ds_enhanced(dsx), .ds_limit(ds_lim), .ds_restart(dsr),
        .gig_fail(gf), .fast_eth_fail(ff), .energy_cd(ecd),
        .speed_sel(spd), .tdr_auto_en(tae), .link_fail(lf),
        .refl_valid(rv), .refl_cross(rc), .refl_time(rt),
        .tdr_done(td), .tdr_start(tst), .tdr_busy(busy),
        .tdr_results_valid(tval), .refl_count(rcnt), .refl_times(rts),
        .cross_found(cfound), .cross_time(ctime), .link_up(lup),
        .signal_bad(sbad), .fast_mode(fm), .crit_en(cen),
        .crit(crit), .link_loss(ll));

    plpm_far_model far_u (.core_clk(core_clk), .sys_rst(sys_rst),
        .plugged(plug), .n_refl(nr), .cross_at(ca), .tdr_start(tst),
        .partner_detect(pdet), .refl_valid(rv), .refl_cross(rc),
        .refl_time(rt), .tdr_done(td));

    initial begin
        forever #2.5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cycles++;
        nlp_n += (nlp === 1'b1);
        ll_n += (ll === 1'b1);
        st_n += (tst === 1'b1);
        sf_n += (sfc === 1'b1);
        if (cycles == 40000) begin
            failures++;
            final_report();
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic chk(input string nm, input logic [15:0] exp,
        input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic tdr_run(input logic [3:0] n, input logic [3:0] c);
        nr = n;
        ca = c;
        st_n = 0;
        lf = 1;
        cyc(1);
        lf = 0;
        chk("tdr_start", 16'h1, 16'(st_n));
        chk("busy", 16'h1, 16'(busy));
        chk("results_valid", 16'h0, 16'(tval));
        for (int k = 0; k < 40 && tval !== 1'b1; k++) cyc(1);
        chk("results_valid", 16'h1, 16'(tval));
        chk("busy", 16'h0, 16'(busy));
    endtask

    initial begin
        cyc(5);
        sys_rst = 0;
        chk("reset", 16'h0001, {pd, slp, spd, 3'h0, macc});
        pdb = 1;
        cyc(2);
        chk("pd bit", 16'h3, {pd, macc});
        // Pin passes its synchroniser before bit clear and soft reset
        pin = 1;
        cyc(3);
        pdb = 0;
        srst = 1;
        cyc(1);
        srst = 0;
        cyc(4);
        chk("pd pin held", 16'h1, 16'(pd));
        pin = 0;
        cyc(5);
        chk("pd clear", 16'h0, 16'(pd));
        pdb = 1;
        cyc(2);
        srst = 1;
        #1 chk("pdown_bit_clear", 16'h1, 16'(pdc));
        cyc(1);
        srst = 0;
        pdb = 0;
        cyc(2);
        chk("pd soft reset", 16'h0, 16'(pd));
        $display("test power done");
        // No auto crossover here, so every sleep code may be written
        for (int c = 0; c < 4; c++) begin
            code = 2'(c);
            swr = 1;
            cyc(1);
            swr = 0;
            cyc(1);
            chk("sleeping", 16'(c >= 2), 16'(slp));
            nlp_n = 0;
            cyc(20);
            chk("nlp", 16'(c == 2), 16'(nlp_n > 0));
            sf_n = 0;
            plug = 1;
            cyc(5);
            chk("wake", 16'h0, 16'(slp));
            chk("sleep clear", 16'(c >= 2), 16'(sf_n));
            plug = 0;
            cyc(3);
        end
        $display("test sleep done");
        mcfg = 1;
        cyc(2);
        chk("mirror gig", 16'h17, {mact, pout});
        dse = 1;
        repeat (3) begin
            gf = 1;
            cyc(1);
            gf = 0;
            cyc(2);
        end
        chk("speed 3 fails", 16'h0, 16'(spd));
        gf = 1;
        cyc(1);
        gf = 0;
        cyc(2);
        chk("speed 4 fails", 16'h1, 16'(spd));
        // Host-side copy of A1h into A0h at 100M is not modelled
        chk("mirror 10/100", 16'h4, 16'(pout));
        mcfg = 0;
        ff = 1;
        cyc(1);
        ff = 0;
        cyc(2);
        chk("speed 10", 16'h5, {spd, pout[0]});
        for (int e = 1; e >= 0; e--) begin
            dsr = 1;
            cyc(1);
            dsr = 0;
            dsx = 1;
            ecd = e[0];
            gf = 1;
            cyc(1);
            gf = 0;
            cyc(2);
            chk("enhanced", 16'(e == 0), 16'(spd));
        end
        lup = 1;
        sbad = 1;
        ll_n = 0;
        cyc(17);
        chk("loss early 100", 16'h0, 16'(ll_n));
        cyc(5);
        chk("loss 100", 16'h1, 16'(ll_n));
        sbad = 0;
        dsr = 1;
        cyc(1);
        dsr = 0;
        $display("test downshift done");
        sbad = 1;
        ll_n = 0;
        cyc(7);
        chk("loss early", 16'h0, 16'(ll_n));
        cyc(5);
        chk("loss default", 16'h1, 16'(ll_n));
        fm = 1;
        for (int i = 0; i < 5; i++) begin
            cen = 5'(1 << i);
            crit = ~cen;
            ll_n = 0;
            cyc(2100);
            chk("fast off", 16'h0, 16'(ll_n));
            crit = cen;
            cyc(2100);
            chk("fast on", 16'h1, 16'(ll_n > 0));
            crit = 0;
        end
        fm = 0;
        sbad = 0;
        $display("test link loss done");
        st_n = 0;
        lf = 1;
        cyc(1);
        lf = 0;
        chk("tdr off", 16'h0, 16'(st_n));
        tae = 1;
        tdr_run(4'h7, 4'hf);
        chk("refl count", 16'h5, 16'(rcnt));
        for (int i = 0; i < 5; i++)
            chk("slot", 16'h0100 + 16'(i), rts[16*i+:16]);
        tdr_run(4'h7, 4'h2);
        chk("cross", 16'h14, {cfound, 1'b0, rcnt});
        chk("cross time", 16'h0102, ctime);
        for (int i = 0; i < 4; i++)
            chk("slot x", 16'h0100 + 16'(i + (i > 1)),
                rts[16*i+:16]);
        $display("test tdr done");
        // Strap is taken once, at the first edge after reset release
        strap = 1;
        sys_rst = 1;
        cyc(5);
        sys_rst = 0;
        chk("reset again", 16'h0, {tval, cfound, rcnt});
        cyc(3);
        chk("strap", 16'h17, {mact, pout});
        $display("test strap done");
        final_report();
    end
endmodule
